// file: cio_core.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - One prescaler is shared between timer zero and the watchdog.
// - Assignment bit one gives the prescaler to the watchdog, zero to timer zero.
// - Timer zero counts undivided only while the prescaler belongs to the watchdog.
// - The option register is read and written at both its addresses and resets to all ones.
// - Pull-ups are enabled by clearing the disable bit, each pin then gated by its select bit.
// - The interrupt control register is one register visible at four addresses.
// - Each flag is set by its event whatever the enable bits are.
// - Timer zero overflow sets its flag and requests an interrupt only when enabled.
// - The external pin sets its flag on the selected edge and is gated by its enable.
// - A change on any selected port pin sets the change flag, gated by its enable.
// - A peripheral enable gates peripheral sources and a global enable gates all.
// - Flags stay set until software writes zero; hardware never clears them.
module cio_core
    import cio_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_srst,
    input  wire logic [CIO_ADDR_W-1:0] i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest,
    input  wire logic                  i_ext_irq_pin,
    input  wire logic                  i_timer_input_pin,
    input  wire logic [CIO_PORT_W-1:0] i_second_io_port,
    input  wire logic                  i_periph_irq_pending,
    input  wire logic                  i_wdt_base_tick,
    output logic                       o_wdt_tick,
    output logic [CIO_PORT_W-1:0]      o_pullup_enable,
    output logic                       o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus: one wait cycle, then the access completes.

    logic                  access_done;
    logic                  bus_req;
    logic                  wr_commit;
    logic [8:0]            reg_index;
    logic                  hit_intctl;
    logic                  hit_options;
    logic                  hit_timer;
    logic                  hit_pullup;
    logic                  hit_change;
    logic                  wr_intctl;
    logic                  wr_options;
    logic                  wr_timer;
    logic                  wr_pullup;
    logic                  wr_change;
    logic [7:0]            wdata;
    logic [7:0]            next_rdata;

    logic [7:0]            options;
    logic [7:0]            intctl;
    logic [7:0]            timer_count;
    logic [CIO_PORT_W-1:0] pullup_sel;
    logic [CIO_PORT_W-1:0] change_sel;

    assign bus_req   = i_avs_read || i_avs_write;
    assign reg_index = i_avs_address[CIO_ADDR_W-1:2];
    assign wdata     = i_avs_writedata[7:0];

    // Only the low byte lane carries register data.
    assign wr_commit = i_avs_write && access_done && i_avs_byteenable[0];

    assign o_avs_waitrequest = bus_req && !access_done;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            access_done <= 1'b0;
        else
            access_done <= bus_req && !access_done;
    end

    // Interrupt control answers in every bank, the option register in banks one and three.
    assign hit_intctl = (reg_index == CIO_IDX_INTCTL_B0)
                     || (reg_index == CIO_IDX_INTCTL_B1)
                     || (reg_index == CIO_IDX_INTCTL_B2)
                     || (reg_index == CIO_IDX_INTCTL_B3);
    assign hit_options = (reg_index == CIO_IDX_OPTIONS_B1)
                      || (reg_index == CIO_IDX_OPTIONS_B3);
    assign hit_timer  = (reg_index == CIO_IDX_TIMER);
    assign hit_pullup = (reg_index == CIO_IDX_PULLUP_SEL);
    assign hit_change = (reg_index == CIO_IDX_CHANGE_SEL);

    assign wr_intctl  = wr_commit && hit_intctl;
    assign wr_options = wr_commit && hit_options;
    assign wr_timer   = wr_commit && hit_timer;
    assign wr_pullup  = wr_commit && hit_pullup;
    assign wr_change  = wr_commit && hit_change;

    // Unmapped addresses read as zero and ignore writes.
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit_intctl)
            next_rdata = intctl;
        else if (hit_options)
            next_rdata = options;
        else if (hit_timer)
            next_rdata = timer_count;
        else if (hit_pullup)
            next_rdata = pullup_sel;
        else if (hit_change)
            next_rdata = change_sel;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read && !access_done)
            o_avs_readdata <= {24'h00_0000, next_rdata};
    end

    ////////////////////////////////////////////////////////////////////////
    // Software control registers.

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            options <= CIO_OPTIONS_RST;
        else if (wr_options)
            options <= wdata;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            pullup_sel <= CIO_PULLUP_SEL_RST;
        else if (wr_pullup)
            pullup_sel <= wdata;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            change_sel <= CIO_CHANGE_SEL_RST;
        else if (wr_change)
            change_sel <= wdata;
    end

    // A pin pulls up only when the port-wide disable is clear.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_pullup_enable <= '0;
        else
            o_pullup_enable <= options[CIO_OPT_PULLUP_DIS] ? '0
                                                           : pullup_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when the last two
    // agree on the new level. Bit 9 is the external interrupt pin, bit 8
    // the timer pin, the rest the second port.

    localparam int NPIN = CIO_PORT_W + 2;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync_s1;
    logic [NPIN-1:0] sync_s2;
    logic [NPIN-1:0] sync_s3;
    logic [NPIN-1:0] pin_level;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;

    assign pin_raw = {i_ext_irq_pin, i_timer_input_pin, i_second_io_port};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++)
        begin : g_sync
            // The stages run through reset, so the level they hold at
            // release is the pin's own and sync_s2 and sync_s3 show no false transition.
            always_ff @(posedge i_mclk)
            begin
                sync_s1[gp] <= pin_raw[gp];
                sync_s2[gp] <= sync_s1[gp];
                sync_s3[gp] <= sync_s2[gp];
            end
            always_ff @(posedge i_mclk)
            begin
                if (i_srst)
                    pin_level[gp] <= 1'b0;
                else if (sync_s2[gp] == sync_s3[gp])
                    pin_level[gp] <= sync_s3[gp];
            end
            assign pin_rise[gp] = (sync_s2[gp] == sync_s3[gp])
                               && sync_s3[gp] && !pin_level[gp];
            assign pin_fall[gp] = (sync_s2[gp] == sync_s3[gp])
                               && !sync_s3[gp] && pin_level[gp];
        end
    endgenerate

    // The first agreement after reset only loads the settled level, so a
    // pin that idles high raises no edge at release.
    logic pins_primed;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            pins_primed <= 1'b0;
        else if (!pins_primed && (sync_s2 == sync_s3))
            pins_primed <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer zero clocking and the shared prescaler.

    logic [1:0] instr_div;
    logic       instr_tick;
    logic       ext_t0_edge;
    logic       t0_src_tick;
    logic       t0_tick;
    logic       t0_overflow;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            instr_div <= 2'b00;
        else
            instr_div <= (instr_div == CIO_INSTR_LAST) ? 2'b00
                                                       : instr_div + 2'b01;
    end

    assign instr_tick = (instr_div == CIO_INSTR_LAST);

    // Source-edge bit one counts falling edges, zero counts rising edges.
    assign ext_t0_edge = pins_primed && (options[CIO_OPT_T0_EDGE]
                                         ? pin_fall[CIO_PORT_W]
                                         : pin_rise[CIO_PORT_W]);
    assign t0_src_tick = options[CIO_OPT_T0_SOURCE] ? ext_t0_edge
                                                    : instr_tick;

    // Changing the assignment or rate restarts the count, so a stale
    // partial count never leaks into the new owner.
    cio_prescaler cio_prescaler_i
    (
        .i_mclk         (i_mclk),
        .i_srst         (i_srst),
        .i_clear        (wr_options || wr_timer),
        .i_assign_wdt   (options[CIO_OPT_PSC_ASSIGN]),
        .i_rate         (options[CIO_OPT_RATE_LSB +: CIO_RATE_W]),
        .i_t0_src_tick  (t0_src_tick),
        .i_wdt_src_tick (i_wdt_base_tick),
        .o_t0_tick      (t0_tick),
        .o_wdt_tick     (o_wdt_tick)
    );

    assign t0_overflow = t0_tick && !wr_timer && (timer_count == 8'hff);

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            timer_count <= CIO_TIMER_RST;
        else if (wr_timer)
            timer_count <= wdata;
        else if (t0_tick)
            timer_count <= timer_count + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events, flags and request.

    logic                  ext_event;
    logic                  chg_event;
    logic [CIO_PORT_W-1:0] port_changed;
    logic [2:0]            flag_events;

    assign ext_event = pins_primed && (options[CIO_OPT_EXT_EDGE]
                                       ? pin_rise[NPIN-1]
                                       : pin_fall[NPIN-1]);
    assign port_changed = pin_rise[CIO_PORT_W-1:0] | pin_fall[CIO_PORT_W-1:0];
    assign chg_event = pins_primed && |(port_changed & change_sel);

    // Events are not qualified by any enable.
    assign flag_events = {t0_overflow, ext_event, chg_event};

    // Enable bits are plain storage.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            intctl[7:3] <= CIO_INTCTL_RST[7:3];
        else if (wr_intctl)
            intctl[7:3] <= wdata[7:3];
    end

    // A hardware event in the same cycle as a software write wins, so an
    // event is never lost to a clear that raced it.
    genvar gf;
    generate
        for (gf = 0; gf < 3; gf++)
        begin : g_flag
            always_ff @(posedge i_mclk)
            begin
                if (i_srst)
                    intctl[gf] <= CIO_INTCTL_RST[gf];
                else if (flag_events[gf])
                    intctl[gf] <= 1'b1;
                else if (wr_intctl)
                    intctl[gf] <= wdata[gf];
            end
        end
    endgenerate

    // A stale flag raises the request as soon as its enable is set; the
    // handler is expected to clear the flag before enabling.
    logic core_pending;
    logic periph_pending;

    assign core_pending =
        (intctl[CIO_IC_T0_FLAG]  && intctl[CIO_IC_T0_EN])
     || (intctl[CIO_IC_EXT_FLAG] && intctl[CIO_IC_EXT_EN])
     || (intctl[CIO_IC_CHG_FLAG] && intctl[CIO_IC_CHG_EN]);
    assign periph_pending = i_periph_irq_pending
                         && intctl[CIO_IC_PERIPH_EN];

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_irq <= 1'b0;
        else
            o_irq <= intctl[CIO_IC_GLOBAL_EN]
                  && (core_pending || periph_pending);
    end

endmodule

`default_nettype wire

// file: cio_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module cio_core_checker
    import cio_pkg::*;
(
    input wire logic                  i_mclk,
    input wire logic                  i_srst,
    input wire logic [CIO_ADDR_W-1:0] i_avs_address,
    input wire logic                  i_avs_read,
    input wire logic                  i_avs_write,
    input wire logic [31:0]           i_avs_writedata,
    input wire logic [3:0]            i_avs_byteenable,
    input wire logic [31:0]           o_avs_readdata,
    input wire logic                  o_avs_waitrequest,
    input wire logic                  i_ext_irq_pin,
    input wire logic                  i_timer_input_pin,
    input wire logic [CIO_PORT_W-1:0] i_second_io_port,
    input wire logic                  i_periph_irq_pending,
    input wire logic                  i_wdt_base_tick,
    input wire logic                  o_wdt_tick,
    input wire logic [CIO_PORT_W-1:0] o_pullup_enable,
    input wire logic                  o_irq
);
    logic [8:0] idx;
    logic       wr_done;
    logic [7:0] opt;
    logic [7:0] ic;

    assign idx = i_avs_address[10:2];
    assign wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];

    // Shadows of software-only bits; hardware never alters them, so reads
    // and gating can be predicted exactly without seeing the flags.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            opt <= CIO_OPTIONS_RST;
        else if (wr_done && idx[7:0] == 8'h81)
            opt <= i_avs_writedata[7:0];
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            ic <= CIO_INTCTL_RST;
        else if (wr_done && idx[6:0] == 7'h0b)
            ic <= i_avs_writedata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    sequence s_req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_req_done;
        (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    endsequence

    property p_one_wait;
        s_req_wait |=> s_req_done;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("access did not end after one wait cycle");
    property p_idle;
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle)
        else $error("waitrequest high with no request");
    property p_opt_read;
        s_req_done ##0 (i_avs_read && idx[7:0] == 8'h81)
            |-> o_avs_readdata == {24'h000000, opt};
    endproperty
    a_opt_read: assert property (p_opt_read)
        else $error("option read differs from written value");
    property p_ic_read;
        s_req_done ##0 (i_avs_read && idx[6:0] == 7'h0b)
            |-> o_avs_readdata[31:3] == {24'h000000, ic[7:3]};
    endproperty
    a_ic_read: assert property (p_ic_read)
        else $error("interrupt control enables differ between addresses");
    property p_wdt_owner;
        !opt[3] && !$past(opt[3]) |-> o_wdt_tick == i_wdt_base_tick;
    endproperty
    a_wdt_owner: assert property (p_wdt_owner)
        else $error("watchdog tick divided while prescaler is with timer");
    property p_wdt_base;
        o_wdt_tick |-> i_wdt_base_tick;
    endproperty
    a_wdt_base: assert property (p_wdt_base)
        else $error("watchdog tick without a base tick");
    property p_pullup_off;
        opt[7] && $past(opt[7]) |-> o_pullup_enable == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-ups enabled while disable bit is set");
    property p_irq_gate;
        !$past(ic[7]) |-> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request raised with global enable clear");
    property p_irq_periph;
        $past(ic[7] && ic[6] && i_periph_irq_pending) |-> o_irq;
    endproperty
    a_irq_periph: assert property (p_irq_periph)
        else $error("enabled peripheral source raised no request");
endmodule

bind cio_core cio_core_checker cio_core_checker_i (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_ext_irq_pin(i_ext_irq_pin), .i_timer_input_pin(i_timer_input_pin),
    .i_second_io_port(i_second_io_port), .o_irq(o_irq),
    .i_periph_irq_pending(i_periph_irq_pending), .o_wdt_tick(o_wdt_tick),
    .i_wdt_base_tick(i_wdt_base_tick), .o_pullup_enable(o_pullup_enable)
);

`default_nettype wire

// file: cio_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cio_core_tb
    import cio_pkg::*;
;
    logic        clk, srst, rds, wrs, ext, tpin, pend, wb, wq, wt, irq;
    logic [10:0] addr;
    logic [31:0] wd, rdd, got;
    logic [3:0]  be;
    logic [7:0]  port, pu;
    int          miscompares, checks;

    cio_core cio_core_i (
        .i_mclk(clk), .i_srst(srst), .i_avs_address(addr),
        .i_avs_read(rds), .i_avs_write(wrs), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdd),
        .o_avs_waitrequest(wq), .i_ext_irq_pin(ext),
        .i_timer_input_pin(tpin), .i_second_io_port(port),
        .i_periph_irq_pending(pend), .i_wdt_base_tick(wb),
        .o_wdt_tick(wt), .o_pullup_enable(pu), .o_irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request is held until waitrequest is sampled low at a rising edge.
    task automatic xfer(input logic w, input logic [8:0] ix,
                        input logic [7:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {ix, 2'b00};
        wrs <= w;
        rds <= !w;
        wd <= {24'h000000, d};
        be <= b;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wq !== 1'b0 && n < 16);
        if (n >= 16)
        begin
            miscompares++;
            stop_test();
        end
        got = rdd;
        wrs <= 1'b0;
        rds <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] ix, input logic [7:0] d);
        xfer(1'b1, ix, d, 4'h1);
    endtask

    task automatic rd(input logic [8:0] ix, input logic [7:0] e);
        xfer(1'b0, ix, 8'h00, 4'h1);
        chk(got, {24'h000000, e});
    endtask

    task automatic wdt_count(input int e);
        int n;
        n = 0;
        repeat (8)
        begin
            wb <= 1'b1;
            @(posedge clk);
            n += (wt === 1'b1) ? 1 : 0;
            wb <= 1'b0;
            @(posedge clk);
        end
        chk(n, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(CIO_IDX_OPTIONS_B1, 8'hff);
        rd(CIO_IDX_INTCTL_B2, 8'h00);
        chk(pu, 8'h00);
        wr(CIO_IDX_OPTIONS_B3, 8'h7a);
        rd(CIO_IDX_OPTIONS_B1, 8'h7a);
        xfer(1'b1, CIO_IDX_OPTIONS_B1, 8'h00, 4'h0);
        rd(CIO_IDX_OPTIONS_B3, 8'h7a);
        rd(9'h050, 8'h00);
        chk(pu, 8'hff);
        wr(CIO_IDX_PULLUP_SEL, 8'ha5);
        cyc(2);
        chk(pu, 8'ha5);
        wr(CIO_IDX_INTCTL_B1, 8'hf8);
        rd(CIO_IDX_INTCTL_B3, 8'hf8);
        wr(CIO_IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_ext();
        ext <= 1'b1;
        cyc(8);
        rd(CIO_IDX_INTCTL_B0, 8'h02);
        chk(irq, 1'b0);
        wr(CIO_IDX_INTCTL_B0, 8'h00);
        ext <= 1'b0;
        cyc(8);
        rd(CIO_IDX_INTCTL_B0, 8'h00);
        wr(CIO_IDX_OPTIONS_B1, 8'h3a);
        ext <= 1'b0;
        cyc(8);
        ext <= 1'b1;
        cyc(8);
        rd(CIO_IDX_INTCTL_B0, 8'h00);
        ext <= 1'b0;
        cyc(8);
        wr(CIO_IDX_INTCTL_B0, 8'h92);
        cyc(3);
        chk(irq, 1'b1);
        cyc(20);
        rd(CIO_IDX_INTCTL_B1, 8'h92);
        wr(CIO_IDX_INTCTL_B0, 8'h90);
        cyc(3);
        chk(irq, 1'b0);
        wr(CIO_IDX_CHANGE_SEL, 8'h01);
        port <= 8'h02;
        cyc(8);
        rd(CIO_IDX_INTCTL_B0, 8'h90);
        port <= 8'h03;
        cyc(8);
        rd(CIO_IDX_INTCTL_B0, 8'h91);
        wr(CIO_IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_timer();
        wr(CIO_IDX_OPTIONS_B1, 8'hcf);
        wr(CIO_IDX_TIMER, 8'hfe);
        cyc(30);
        rd(CIO_IDX_INTCTL_B0, 8'h04);
        chk(irq, 1'b0);
        wr(CIO_IDX_TIMER, 8'h00);
        cyc(80);
        xfer(1'b0, CIO_IDX_TIMER, 8'h00, 4'h1);
        chk(got inside {[19:23]}, 1);
        wr(CIO_IDX_OPTIONS_B1, 8'hc0);
        wr(CIO_IDX_TIMER, 8'h00);
        cyc(80);
        xfer(1'b0, CIO_IDX_TIMER, 8'h00, 4'h1);
        chk(got inside {[9:12]}, 1);
        wr(CIO_IDX_OPTIONS_B1, 8'hef);
        wr(CIO_IDX_TIMER, 8'h00);
        repeat (5)
        begin
            tpin <= 1'b1;
            cyc(4);
            tpin <= 1'b0;
            cyc(4);
        end
        cyc(6);
        rd(CIO_IDX_TIMER, 8'h05);
        wr(CIO_IDX_OPTIONS_B1, 8'hff);
        repeat (3)
        begin
            tpin <= 1'b1;
            cyc(4);
            tpin <= 1'b0;
            cyc(4);
        end
        cyc(6);
        rd(CIO_IDX_TIMER, 8'h08);
        wr(CIO_IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_misc();
        wr(CIO_IDX_OPTIONS_B1, 8'hea);
        wdt_count(2);
        wr(CIO_IDX_OPTIONS_B1, 8'he2);
        wdt_count(8);
        wr(CIO_IDX_INTCTL_B0, 8'hc0);
        pend <= 1'b1;
        cyc(3);
        chk(irq, 1'b1);
        wr(CIO_IDX_INTCTL_B0, 8'h80);
        cyc(3);
        chk(irq, 1'b0);
        pend <= 1'b0;
    endtask

    initial
    begin
        {srst, rds, wrs, ext, tpin, pend, wb} = 7'h40;
        {addr, wd, be, port} = '0;
        miscompares = 0;
        checks = 0;
        cyc(16);
        srst <= 1'b0;
        t_regs();
        t_ext();
        t_timer();
        t_misc();
        stop_test();
    end

    initial
    begin
        cyc(20000);
        miscompares++;
        stop_test();
    end
endmodule

`default_nettype wire

// file: cio_pkg.sv
`default_nettype none

package cio_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [8:0] CIO_IDX_INTCTL_B0  = 9'h00b;
    localparam logic [8:0] CIO_IDX_INTCTL_B1  = 9'h08b;
    localparam logic [8:0] CIO_IDX_INTCTL_B2  = 9'h10b;
    localparam logic [8:0] CIO_IDX_INTCTL_B3  = 9'h18b;
    localparam logic [8:0] CIO_IDX_OPTIONS_B1 = 9'h081;
    localparam logic [8:0] CIO_IDX_OPTIONS_B3 = 9'h181;
    localparam logic [8:0] CIO_IDX_TIMER      = 9'h001;
    localparam logic [8:0] CIO_IDX_PULLUP_SEL = 9'h095;
    localparam logic [8:0] CIO_IDX_CHANGE_SEL = 9'h096;

    localparam int CIO_ADDR_W = 11;
    localparam int CIO_PORT_W = 8;

    // Option register fields.
    localparam int CIO_OPT_PULLUP_DIS = 7;
    localparam int CIO_OPT_EXT_EDGE   = 6;
    localparam int CIO_OPT_T0_SOURCE  = 5;
    localparam int CIO_OPT_T0_EDGE    = 4;
    localparam int CIO_OPT_PSC_ASSIGN = 3;
    localparam int CIO_OPT_RATE_LSB   = 0;
    localparam int CIO_RATE_W         = 3;

    // Interrupt control fields.
    localparam int CIO_IC_GLOBAL_EN = 7;
    localparam int CIO_IC_PERIPH_EN = 6;
    localparam int CIO_IC_T0_EN     = 5;
    localparam int CIO_IC_EXT_EN    = 4;
    localparam int CIO_IC_CHG_EN    = 3;
    localparam int CIO_IC_T0_FLAG   = 2;
    localparam int CIO_IC_EXT_FLAG  = 1;
    localparam int CIO_IC_CHG_FLAG  = 0;

    // Reset values.
    localparam logic [7:0] CIO_OPTIONS_RST    = 8'hff;
    localparam logic [7:0] CIO_INTCTL_RST     = 8'h00;
    localparam logic [7:0] CIO_TIMER_RST      = 8'h00;
    localparam logic [7:0] CIO_PULLUP_SEL_RST = 8'hff;
    localparam logic [7:0] CIO_CHANGE_SEL_RST = 8'h00;

    // Instruction clock is the core clock divided by four.
    localparam int         CIO_INSTR_DIV  = 4;
    localparam logic [1:0] CIO_INSTR_LAST = 2'(CIO_INSTR_DIV - 1);

    localparam int CIO_SYNC_STAGES = 3;

endpackage

`default_nettype wire

// file: cio_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module cio_prescaler
    import cio_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_srst,
    input  wire logic                  i_clear,
    input  wire logic                  i_assign_wdt,
    input  wire logic [CIO_RATE_W-1:0] i_rate,
    input  wire logic                  i_t0_src_tick,
    input  wire logic                  i_wdt_src_tick,
    output logic                       o_t0_tick,
    output logic                       o_wdt_tick
);

    logic [7:0] count;
    logic [3:0] shift;
    logic [7:0] mask;
    logic       src_tick;
    logic       div_tick;

    ////////////////////////////////////////////////////////////////////////
    // One counter serves whichever unit owns it.
    assign src_tick = i_assign_wdt ? i_wdt_src_tick : i_t0_src_tick;

    // Timer zero sees one extra halving, so its steps start at 1:2.
    assign shift = i_assign_wdt ? {1'b0, i_rate}
                                : {1'b0, i_rate} + 4'h1;
    assign mask = 8'((9'h001 << shift) - 9'h001);
    assign div_tick = src_tick && ((count & mask) == mask);

    always_ff @(posedge i_mclk)
    begin
        if (i_srst || i_clear)
            count <= 8'h00;
        else if (src_tick)
            count <= count + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // The unit that does not own the prescaler runs undivided.
    assign o_t0_tick  = i_assign_wdt ? i_t0_src_tick : div_tick;
    assign o_wdt_tick = i_assign_wdt ? div_tick : i_wdt_src_tick;

endmodule

`default_nettype wire
